// *** rtl/wdtc_map.svh ***
/*
 Register indices, field positions, reset values and divider taps of the
 watchdog and tick control block. Assumes a 32-bit AXI4-Lite register bus.
*/
`ifndef WDTC_MAP_SVH
`define WDTC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define WDTC_ADDR_W 17
`define WDTC_IDX_COUNT 15'h7023
`define WDTC_IDX_KEY 15'h7025
`define WDTC_IDX_TICK 15'h7027
`define WDTC_IDX_CTRL 15'h7029
`define WDTC_IDX_STAT 15'h7030
`define WDTC_IDX_MASK 15'h7031

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define WDTC_CTRL_FLAG_BIT 7
`define WDTC_CTRL_DIS_BIT 6
`define WDTC_GUARD_PATTERN 3'h5
`define WDTC_TICK_EN_BIT 6
`define WDTC_KEY_ARM 8'h55
`define WDTC_KEY_FIRE 8'hAA
`define WDTC_STAT_TICK 0
`define WDTC_STAT_DOG 1
`define WDTC_RESP_OKAY 2'h0
`define WDTC_RESP_SLVERR 2'h2
`define WDTC_SEL_RESET 3'h0
`define WDTC_DOG_STEPS 9'h101

// ----------------------------------------------------------------------
// Prescaler taps: low-bit masks that must read zero at an overflow
// ----------------------------------------------------------------------
`define WDTC_TICK_TAP0 14'h0003
`define WDTC_TICK_TAP1 14'h000F
`define WDTC_TICK_TAP2 14'h003F
`define WDTC_TICK_TAP3 14'h007F
`define WDTC_TICK_TAP4 14'h00FF
`define WDTC_TICK_TAP5 14'h01FF
`define WDTC_TICK_TAP6 14'h07FF
`define WDTC_TICK_TAP7 14'h3FFF
`define WDTC_DOG_TAP1 14'h0000
`define WDTC_DOG_TAP2 14'h0001
`define WDTC_DOG_TAP3 14'h0003
`define WDTC_DOG_TAP4 14'h0007
`define WDTC_DOG_TAP5 14'h000F
`define WDTC_DOG_TAP6 14'h001F
`define WDTC_DOG_TAP7 14'h003F

`endif

// *** rtl/wdtc_pkg.sv ***
/*
 Types of the watchdog and tick control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package wdtc_pkg;

	// Service key sequencer
	typedef enum logic [1:0] {KEY_IDLE = 2'b01, KEY_ARMED = 2'b10} wdtc_key_st_t;

	// Watchdog overflow sequencer
	typedef enum logic [1:0] {DOG_RUN = 2'b01, DOG_LAST = 2'b10} wdtc_dog_st_t;

endpackage

// *** rtl/wdtc_prescaler.sv ***
/*
 Free-running prescaler of the slow timer clock.
 Assumes the slow clock pin is asynchronous to aclk and far slower.
*/
`timescale 1ns/1ns
module wdtc_prescaler
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic slow_clk_pin,
	output logic slow_tick,
	output logic [13:0] presc_cnt
);

	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic tick_r;
	logic [13:0] cnt_r;

	// ------------------------------------------------------------------
	// Pin synchroniser, left unreset since it only carries samples
	// ------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (ce)
		begin
			sync1_r <= slow_clk_pin;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Count rising edges; never cleared by servicing, only by reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tick_r <= 1'b0;
			cnt_r <= 14'h0000;
		end
		else if (ce)
		begin
			tick_r <= sync2_r & ~sync3_r;
			if (sync2_r & ~sync3_r)
				cnt_r <= cnt_r + 14'h0001;
		end
	end

	assign slow_tick = tick_r;
	assign presc_cnt = cnt_r;

endmodule

// *** rtl/wdtc_top.sv ***
/*
 Watchdog and periodic tick control block with an AXI4-Lite slave.
 Assumes a 125 MHz aclk, a slow timer clock pin far slower than aclk and
 a system reset controller that acts on the one-cycle reset request.
*/
// Functional notes
// R1 - Tick tap select codes 0..7 divide slow clock by 4,16,64,128,256,512,2048,16384.
// R2 - Software always writes 101 into guard bits five down to three.
// R3 - Control write with wrong guard pattern requests a system reset.
// R4 - Guard bits always read back as zero.
// R5 - Reset flag set by watchdog reset only, held until software clears it.
// R6 - Disable bit honoured only when the high-voltage option was caught at reset.
// R7 - Watchdog tap codes 00x divide by 1, then 2 up to 64.
// R8 - Watchdog counts 257 prescaled clocks from clear before resetting.
// R9 - Servicing does not clear the prescaler.
// R10 - Software services the counter before every overflow.
// R11 - After disabling, software services once to clear any pending request.
// R12 - Key 55h then AAh clears the counter; any other key resets.
// R13 - After overflow one more prescaled cycle passes before reset.
// R14 - Tick flag on each overflow; enabled tick raises one request; disable drops it.
// R15 - Reading the key register returns the control register.
// R16 - Disable, guard and prescale fields reset to zero.
`timescale 1ns/1ns
`include "wdtc_map.svh"
module wdtc_top
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic poresetn,
	input wire logic ce,
	input wire logic slow_timer_clock,
	input wire logic prog_supply_high,
	input wire logic tick_ack,
	input wire logic awvalid,
	output logic awready,
	input wire logic [16:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [16:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic sys_reset_req,
	output logic irq,
	output logic periodic_tick_interrupt
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [14:0] wr_idx_r;
	logic [7:0] wr_data_r;
	logic wr_lane_r;
	logic wr_go, wr_hit;
	logic [14:0] rd_idx;
	logic [7:0] rd_val;
	logic rd_hit;
	logic [13:0] presc;
	logic slow_tick;
	logic hv_s1_r, hv_s2_r, hv_opt_r, hv_done_r;
	logic dog_flag_r, dog_dis_r;
	logic [2:0] dog_sel_r, tick_sel_r;
	logic tick_flag_r, tick_en_r, tick_irq_r;
	logic [7:0] dog_cnt_r;
	wdtc_pkg::wdtc_dog_st_t dog_st_r;
	wdtc_pkg::wdtc_key_st_t key_st_r;
	logic [1:0] stat_r, mask_r;
	logic irq_r, sys_reset_r;
	logic [13:0] tick_mask, dog_mask;
	logic tick_ovf, dog_step, dog_run, dog_fire, dog_ovf;
	logic wr_ctrl, wr_key, wr_tick, guard_bad, key_bad, key_clear;
	logic rd_stat;
	logic [7:0] ctrl_view;

	// ------------------------------------------------------------------
	// Slow clock prescaler
	// ------------------------------------------------------------------
	wdtc_prescaler u_presc
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.slow_clk_pin(slow_timer_clock),
		.slow_tick(slow_tick),
		.presc_cnt(presc)
	);

	// R1 tick tap decode
	always_comb
	begin
		case (tick_sel_r)
			3'h0: tick_mask = `WDTC_TICK_TAP0;
			3'h1: tick_mask = `WDTC_TICK_TAP1;
			3'h2: tick_mask = `WDTC_TICK_TAP2;
			3'h3: tick_mask = `WDTC_TICK_TAP3;
			3'h4: tick_mask = `WDTC_TICK_TAP4;
			3'h5: tick_mask = `WDTC_TICK_TAP5;
			3'h6: tick_mask = `WDTC_TICK_TAP6;
			default: tick_mask = `WDTC_TICK_TAP7;
		endcase
	end

	// R7 watchdog tap decode, codes 0 and 1 share the undivided tap
	always_comb
	begin
		case (dog_sel_r)
			3'h2: dog_mask = `WDTC_DOG_TAP2;
			3'h3: dog_mask = `WDTC_DOG_TAP3;
			3'h4: dog_mask = `WDTC_DOG_TAP4;
			3'h5: dog_mask = `WDTC_DOG_TAP5;
			3'h6: dog_mask = `WDTC_DOG_TAP6;
			3'h7: dog_mask = `WDTC_DOG_TAP7;
			default: dog_mask = `WDTC_DOG_TAP1;
		endcase
	end

	// An overflow is the cycle the selected low bits have just wrapped
	assign tick_ovf = slow_tick && ((presc & tick_mask) == 14'h0000);
	assign dog_step = slow_tick && ((presc & dog_mask) == 14'h0000);
	// R6 disable only counts when the option was caught at reset
	assign dog_run = !(hv_opt_r && dog_dis_r);
	// R13 fire one prescaled step after the counter wrapped
	assign dog_fire = dog_step && dog_run && (dog_st_r == wdtc_pkg::DOG_LAST);
	assign dog_ovf = dog_step && dog_run && (dog_st_r == wdtc_pkg::DOG_RUN)
		&& (dog_cnt_r == 8'hFF);

	// ------------------------------------------------------------------
	// AXI4-Lite write channel: address and data taken in either order
	// ------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= `WDTC_RESP_OKAY;
			wr_idx_r <= 15'h0000;
			wr_data_r <= 8'h00;
			wr_lane_r <= 1'b0;
		end
		else if (ce)
		begin
			if (awvalid && awready_r)
			begin
				awready_r <= 1'b0;
				wr_idx_r <= awaddr[16:2];
			end
			if (wvalid && wready_r)
			begin
				wready_r <= 1'b0;
				wr_data_r <= wdata[7:0];
				wr_lane_r <= wstrb[0];
			end
			if (wr_go)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? `WDTC_RESP_OKAY : `WDTC_RESP_SLVERR;
			end
			else if (bvalid_r && bready)
			begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// The write takes effect once both halves are held
	assign wr_go = !awready_r && !wready_r && !bvalid_r;
	assign wr_hit = (wr_idx_r == `WDTC_IDX_COUNT) || (wr_idx_r == `WDTC_IDX_KEY)
		|| (wr_idx_r == `WDTC_IDX_TICK) || (wr_idx_r == `WDTC_IDX_CTRL)
		|| (wr_idx_r == `WDTC_IDX_STAT) || (wr_idx_r == `WDTC_IDX_MASK);
	// Only the low byte lane carries register data
	assign wr_ctrl = wr_go && wr_lane_r && (wr_idx_r == `WDTC_IDX_CTRL);
	assign wr_key = wr_go && wr_lane_r && (wr_idx_r == `WDTC_IDX_KEY);
	assign wr_tick = wr_go && wr_lane_r && (wr_idx_r == `WDTC_IDX_TICK);
	// R3 guard check on every control write
	assign guard_bad = wr_ctrl && (wr_data_r[5:3] != `WDTC_GUARD_PATTERN);
	// R12 key check: only the two key values are tolerated
	assign key_bad = wr_key && (wr_data_r != `WDTC_KEY_ARM)
		&& (wr_data_r != `WDTC_KEY_FIRE);
	assign key_clear = wr_key && (wr_data_r == `WDTC_KEY_FIRE)
		&& (key_st_r == wdtc_pkg::KEY_ARMED);

	// ------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------
	assign rd_idx = araddr[16:2];
	// R4 guard bits always read as zero
	assign ctrl_view = {dog_flag_r, dog_dis_r, 3'h0, dog_sel_r};

	// Read mux; an unmapped index answers zero with an error
	always_comb
	begin
		rd_hit = 1'b1;
		if (rd_idx == `WDTC_IDX_COUNT)
			rd_val = dog_cnt_r;
		// R15 key register reads back the control register
		else if ((rd_idx == `WDTC_IDX_KEY) || (rd_idx == `WDTC_IDX_CTRL))
			rd_val = ctrl_view;
		else if (rd_idx == `WDTC_IDX_TICK)
			rd_val = {tick_flag_r, tick_en_r, 3'h0, tick_sel_r};
		else if (rd_idx == `WDTC_IDX_STAT)
			rd_val = {6'h00, stat_r};
		else if (rd_idx == `WDTC_IDX_MASK)
			rd_val = {6'h00, mask_r};
		else
		begin
			rd_val = 8'h00;
			rd_hit = 1'b0;
		end
	end

	assign rd_stat = arvalid && arready_r && (rd_idx == `WDTC_IDX_STAT);

	// One read at a time; data registered one cycle after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `WDTC_RESP_OKAY;
		end
		else if (ce)
		begin
			if (arvalid && arready_r)
			begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= {24'h000000, rd_val};
				rresp_r <= rd_hit ? `WDTC_RESP_OKAY : `WDTC_RESP_SLVERR;
			end
			else if (rvalid_r && rready)
			begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// High-voltage option, caught once after reset release
	// ------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (ce)
		begin
			hv_s1_r <= prog_supply_high;
			hv_s2_r <= hv_s1_r;
		end
	end

	// R6 latch the supply level once; later changes are ignored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hv_opt_r <= 1'b0;
			hv_done_r <= 1'b0;
		end
		else if (ce && !hv_done_r)
		begin
			hv_opt_r <= hv_s2_r;
			hv_done_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------------
	// R16 fields cleared by reset, shortest timeout
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dog_dis_r <= 1'b0;
			dog_sel_r <= `WDTC_SEL_RESET;
		end
		else if (ce && wr_ctrl && !guard_bad)
		begin
			dog_dis_r <= wr_data_r[`WDTC_CTRL_DIS_BIT];
			dog_sel_r <= wr_data_r[2:0];
		end
	end

	// R5 flag survives system reset; only power-on or a software zero clears it, set wins
	always_ff @(posedge aclk)
	begin
		if (!poresetn)
			dog_flag_r <= 1'b0;
		else if (ce)
		begin
			if (dog_fire)
				dog_flag_r <= 1'b1;
			else if (wr_ctrl && !guard_bad && !wr_data_r[`WDTC_CTRL_FLAG_BIT])
				dog_flag_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Service key sequencer
	// ------------------------------------------------------------------
	// R12 arm on 55h, fire on AAh; repeated keys keep their meaning
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			key_st_r <= wdtc_pkg::KEY_IDLE;
		else if (ce && wr_key)
		begin
			case (key_st_r)
				wdtc_pkg::KEY_IDLE:
					if (wr_data_r == `WDTC_KEY_ARM)
						key_st_r <= wdtc_pkg::KEY_ARMED;
				wdtc_pkg::KEY_ARMED:
					if (wr_data_r != `WDTC_KEY_ARM)
						key_st_r <= wdtc_pkg::KEY_IDLE;
				default:
					key_st_r <= wdtc_pkg::KEY_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Watchdog counter and overflow sequencer
	// ------------------------------------------------------------------
	// R8 counter steps once per prescaled clock; R9 prescaler untouched
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dog_cnt_r <= 8'h00;
			dog_st_r <= wdtc_pkg::DOG_RUN;
		end
		else if (ce)
		begin
			if (key_clear)
			begin
				dog_cnt_r <= 8'h00;
				dog_st_r <= wdtc_pkg::DOG_RUN;
			end
			else if (dog_step && dog_run)
			begin
				case (dog_st_r)
					wdtc_pkg::DOG_RUN:
					begin
						dog_cnt_r <= dog_cnt_r + 8'h01;
						if (dog_cnt_r == 8'hFF)
							dog_st_r <= wdtc_pkg::DOG_LAST;
					end
					wdtc_pkg::DOG_LAST:
						dog_st_r <= wdtc_pkg::DOG_RUN;
					default:
						dog_st_r <= wdtc_pkg::DOG_RUN;
				endcase
			end
		end
	end

	// R3 one-cycle system reset request from any of three causes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sys_reset_r <= 1'b0;
		else if (ce)
			sys_reset_r <= guard_bad || key_bad || dog_fire;
	end

	// ------------------------------------------------------------------
	// Tick control and request
	// ------------------------------------------------------------------
	// R14 flag set on every overflow; a software zero clears, set wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tick_flag_r <= 1'b0;
			tick_en_r <= 1'b0;
			tick_sel_r <= `WDTC_SEL_RESET;
		end
		else if (ce)
		begin
			if (tick_ovf)
				tick_flag_r <= 1'b1;
			else if (wr_tick && !wr_data_r[7])
				tick_flag_r <= 1'b0;
			if (wr_tick)
			begin
				tick_en_r <= wr_data_r[`WDTC_TICK_EN_BIT];
				tick_sel_r <= wr_data_r[2:0];
			end
		end
	end

	// R14 request raised at the overflow, dropped by ack or by disable
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tick_irq_r <= 1'b0;
		else if (ce)
		begin
			if (!tick_en_r)
				tick_irq_r <= 1'b0;
			else if (tick_ovf)
				tick_irq_r <= 1'b1;
			else if (tick_ack)
				tick_irq_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Sticky status, mask and interrupt line
	// ------------------------------------------------------------------
	// A status read clears the bits it returned; a new event still wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stat_r <= 2'h0;
			mask_r <= 2'h0;
			irq_r <= 1'b0;
		end
		else if (ce)
		begin
			stat_r[`WDTC_STAT_TICK] <= tick_ovf || (stat_r[`WDTC_STAT_TICK] && !rd_stat);
			stat_r[`WDTC_STAT_DOG] <= dog_ovf || (stat_r[`WDTC_STAT_DOG] && !rd_stat);
			if (wr_go && wr_lane_r && (wr_idx_r == `WDTC_IDX_MASK))
				mask_r <= wr_data_r[1:0];
			irq_r <= |(stat_r & mask_r);
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign sys_reset_req = sys_reset_r;
	assign irq = irq_r;
	assign periodic_tick_interrupt = tick_irq_r;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [8:0] steps_r;
	logic rd_ctrl_r;
	logic [3:0] tick_exp;

	// Tap exponent of each tick code, built apart from the mask table
	assign tick_exp = (tick_sel_r < 3'h3) ? {tick_sel_r, 1'b0} + 4'h2
		: (tick_sel_r < 3'h6) ? {1'b0, tick_sel_r} + 4'h4 : (tick_sel_r == 3'h6) ? 4'hB : 4'hE;

	// Prescaled steps since the last clear, for the timeout check
	always_ff @(posedge aclk)
	begin
		if (!aresetn || key_clear)
			steps_r <= 9'h000;
		else if (ce && dog_step && dog_run && (steps_r != 9'h1FF))
			steps_r <= steps_r + 9'h001;
	end

	// Remembers that the pending read targets the key or control view
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_ctrl_r <= 1'b0;
		else if (ce && arvalid && arready_r)
			rd_ctrl_r <= (rd_idx == `WDTC_IDX_KEY) || (rd_idx == `WDTC_IDX_CTRL);
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_tick_tap_hit: assert property (slow_tick |-> tick_ovf == ((presc % (15'h0001 << tick_exp)) == 15'h0000)) // R1
		else $error("tick overflow off its tap");
	a_guard_bad_reset: assert property (guard_bad && ce |=> sys_reset_req) // R3
		else $error("bad guard write did not reset");
	a_guard_read_zero: assert property (rvalid && rd_ctrl_r |-> rdata[5:3] == 3'h0) // R4
		else $error("guard bits read nonzero");
	a_flag_on_fire: assert property (dog_fire && ce && poresetn |=> dog_flag_r) // R5
		else $error("watchdog flag not set");
	a_disable_holds: assert property (hv_opt_r && dog_dis_r |-> !dog_fire && !dog_ovf) // R6
		else $error("disabled watchdog advanced");
	a_dog_tap_hit: assert property (slow_tick |-> dog_step == ((presc % (15'h0001 << // R7
		((dog_sel_r < 3'h2) ? 3'h0 : dog_sel_r - 3'h1))) == 15'h0000))
		else $error("watchdog step off its tap");
	a_fire_after_257: assert property (dog_fire |-> steps_r == `WDTC_DOG_STEPS - 9'h001) // R8
		else $error("watchdog fired at wrong count");
	a_presc_kept: assert property (key_clear && !slow_tick ##1 !slow_tick |-> $stable(presc)) // R9
		else $error("service disturbed prescaler");
	a_key_clears: assert property (key_clear && ce |=> dog_cnt_r == 8'h00) // R12
		else $error("valid key did not clear counter");
	a_key_bad_reset: assert property (key_bad && ce |=> sys_reset_req) // R12
		else $error("bad key did not reset");
	a_last_chance: assert property (dog_ovf && ce |=> dog_st_r == wdtc_pkg::DOG_LAST && !sys_reset_req) // R13
		else $error("overflow reset too early");
	a_tick_drop: assert property (!tick_en_r && ce |=> !periodic_tick_interrupt) // R14
		else $error("tick request survived disable");
	a_key_readback: assert property (rvalid && rd_ctrl_r && $rose(rvalid) |-> rdata[7:0] == $past(ctrl_view)) // R15
		else $error("key read did not mirror control");
	a_reset_fields: assert property ($past(!aresetn) |-> dog_dis_r == 1'b0 && dog_sel_r == 3'h0) // R16
		else $error("control fields not cleared");

	c_key_service: cover property (key_clear);
	c_dog_fire: cover property (dog_fire ##1 sys_reset_req);
	c_tick_request: cover property ($rose(periodic_tick_interrupt));
	c_guard_reset: cover property (guard_bad);

endmodule

// *** sim/wdtc_testbench.sv ***
/*
 Self-checking bench of the watchdog and tick control block.
 Assumes the design files under rtl/; the bench makes the slow timer clock.
*/
`timescale 1ns/1ns
`include "wdtc_map.svh"
module testbench;

// ----------------------------------------------------------------------
// Signals
// ----------------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn, poresetn, ce, slow, hv;
	logic tick_ack = 1'b0;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic sys_reset_req, irq, periodic_tick_interrupt;
	logic [16:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_data;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rd_resp, wr_resp;
	int error_cnt = 0;
	int comparisons = 0;
	int rst_cnt = 0;
	int tk_cnt = 0;
	int r0, k0;
	int dog_div[8] = '{1, 1, 2, 4, 8, 16, 32, 64};
	int tick_div[6] = '{4, 16, 64, 128, 256, 512};

	wdtc_top i_wdtc_top
	(
		.aclk, .aresetn, .poresetn, .ce, .slow_timer_clock(slow),
		.prog_supply_high(hv), .tick_ack, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.sys_reset_req, .irq, .periodic_tick_interrupt
	);

	// 125 MHz bus clock
	always #4 aclk = ~aclk;

	// Pulse counters; each tick request is acknowledged the cycle after it shows
	always @(posedge aclk)
	begin
		tick_ack <= periodic_tick_interrupt;
		if (sys_reset_req === 1'b1)
			rst_cnt <= rst_cnt + 1;
		if (periodic_tick_interrupt === 1'b1 && tick_ack === 1'b0)
			tk_cnt <= tk_cnt + 1;
	end

// ----------------------------------------------------------------------
// Tasks
// ----------------------------------------------------------------------
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Write one register; address and data released each when taken
	task automatic wr(input logic [14:0] idx, input logic [7:0] d);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		bready <= 1'b1;
		while (!(a && w))
		begin
			@(posedge aclk);
			if (!a && awready === 1'b1)
			begin
				a = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1)
			begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		wr_resp = bresp;
	endtask

	// Read one register into rd_data and rd_resp
	task automatic rd(input logic [14:0] idx);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= {idx, 2'b00};
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		rd_data = rdata;
		rd_resp = rresp;
	endtask

	task automatic rdc(input logic [14:0] idx, input logic [31:0] exp, input string nm);
		rd(idx);
		chk(nm, rd_data, exp);
	endtask

	// Service sequence: arm key then fire key
	task automatic svc();
		wr(`WDTC_IDX_KEY, `WDTC_KEY_ARM);
		wr(`WDTC_IDX_KEY, `WDTC_KEY_FIRE);
	endtask

	// Slow clock edges, then time for the two-flop synchroniser to settle
	task automatic sl(input int n);
		repeat (n)
		begin
			slow <= 1'b1;
			repeat (4) @(posedge aclk);
			slow <= 1'b0;
			repeat (4) @(posedge aclk);
		end
		repeat (8) @(posedge aclk);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

// ----------------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------------
	// Slow clock stays still during pure register tests so the dog cannot fire
	initial
	begin
		{aresetn, poresetn, slow, hv, awvalid, wvalid} = 6'h00;
		{bready, arvalid, rready, awaddr, araddr, wstrb} = 41'h0;
		wdata = 32'h0;
		ce = 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		poresetn <= 1'b1;
		rdc(`WDTC_IDX_CTRL, 32'h00, "ctrl reset"); // fields cleared
		rd(15'h7020);
		chk("unmapped resp", rd_resp, `WDTC_RESP_SLVERR);
		wr(15'h7020, 8'h00);
		chk("unmapped write resp", wr_resp, `WDTC_RESP_SLVERR);
		wr(`WDTC_IDX_CTRL, 8'h2F); // guard pattern
		chk("write resp", wr_resp, `WDTC_RESP_OKAY);
		rdc(`WDTC_IDX_CTRL, 32'h07, "ctrl guard"); // guard reads zero
		chk("read resp", rd_resp, `WDTC_RESP_OKAY);
		rdc(`WDTC_IDX_KEY, 32'h07, "key read"); // key shows ctrl
		r0 = rst_cnt;
		wr(`WDTC_IDX_CTRL, 8'h07);
		repeat (2) @(posedge aclk);
		chk("bad guard reset", rst_cnt - r0, 32'h1); // bad guard
		rdc(`WDTC_IDX_CTRL, 32'h07, "ctrl kept"); // fields kept
		wr(`WDTC_IDX_KEY, 8'h12);
		repeat (2) @(posedge aclk);
		chk("bad key reset", rst_cnt - r0, 32'h2); // bad key
		// Option low: disable bit is ignored and the dog keeps counting
		wr(`WDTC_IDX_CTRL, 8'h68);
		svc();
		sl(3);
		rdc(`WDTC_IDX_COUNT, 32'h03, "count enabled"); // option low
		// Any window of four periods holds exactly four steps
		for (int c = 0; c < 8; c++)
		begin
			wr(`WDTC_IDX_CTRL, 8'h28 | c[7:0]);
			svc(); // service before overflow
			sl(4 * dog_div[c]);
			rdc(`WDTC_IDX_COUNT, 32'h04, "dog tap"); // tap and service
		end
		// Full timeout at divide by one
		wr(`WDTC_IDX_MASK, 8'h02);
		wr(`WDTC_IDX_CTRL, 8'h28);
		svc();
		r0 = rst_cnt;
		sl(256);
		chk("no early reset", rst_cnt - r0, 32'h0); // last chance
		chk("irq raised", irq, 32'h1); // overflow status
		rdc(`WDTC_IDX_STAT, 32'h03, "status");
		repeat (2) @(posedge aclk);
		chk("irq cleared", irq, 32'h0); // status read clears
		sl(1);
		chk("dog reset", rst_cnt - r0, 32'h1); // step count
		rdc(`WDTC_IDX_CTRL, 32'h80, "flag set"); // flag on dog reset
		// Second reset with the option high; the flag must survive it
		hv <= 1'b1;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`WDTC_IDX_CTRL, 32'h80, "flag kept"); // other reset
		wr(`WDTC_IDX_CTRL, 8'h68);
		rdc(`WDTC_IDX_CTRL, 32'h40, "flag cleared"); // cleared, disabled
		svc(); // service after disabling
		r0 = rst_cnt;
		sl(300);
		rdc(`WDTC_IDX_COUNT, 32'h00, "dog frozen"); // disable honoured
		chk("no reset", rst_cnt - r0, 32'h0); // no timeout
		// The counter is read-only; a write must leave it alone
		wr(`WDTC_IDX_COUNT, 8'h55);
		rdc(`WDTC_IDX_COUNT, 32'h00, "count write ignored");
		// Two periods hold exactly two tick requests; long taps only set
		for (int c = 0; c < 8; c++)
		begin
			wr(`WDTC_IDX_TICK, 8'h40 | c[7:0]);
			k0 = tk_cnt;
			if (c < 6)
			begin
				sl(2 * tick_div[c]);
				chk("tick pulses", tk_cnt - k0, 32'h2); // tick tap
			end
			rdc(`WDTC_IDX_TICK, (c < 6 ? 32'hC0 : 32'h40) | c, "tick ctrl"); // flag
		end
		end_of_test();
	end

	// Hang guard, about two and a half times the expected run length
	initial
	begin
		#480000;
		error_cnt++;
		end_of_test();
	end

endmodule
